// ===== src/clb_top.sv
`timescale 1ns/100ps
`default_nettype none
module clb_top import clb_pkg::*; #(
   parameter int N_SINGLE = 64,
   parameter int N_DOUBLE = 16,
   parameter int N_EXT = 32,
   parameter int TICK_CYC = CLB_TICK_CYC
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire clb_qsig_s [N_EXT-1:0] ext_sig,
   input wire logic latch_clr,
   output clb_qsig_s [N_SINGLE-1:0] single_sig,
   output logic [2*N_DOUBLE-1:0] double_pat,
   output logic tick
);
   localparam int POOL = N_EXT + N_DOUBLE + N_SINGLE;
   localparam int NIN = CLB_N_SET * CLB_N_IN;
   localparam int TICK_W = $clog2(TICK_CYC + 1);
   localparam int BL_W = $clog2(CLB_BLINK_HALF + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
   localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
   localparam logic [BL_W-1:0] BL_LAST = BL_W'(CLB_BLINK_HALF - 1);
   localparam logic [BL_W-1:0] BL_ONE = BL_W'(1);

   typedef struct packed {
      clb_inp_s [N_SINGLE-1:0][NIN-1:0] inp;
      clb_ctrl_s [N_SINGLE-1:0] ctrl;
      logic [N_SINGLE-1:0][CLB_TIME_W-1:0] stime;
      clb_dcfg_s [N_DOUBLE-1:0] dcfg;
      logic [N_SINGLE-1:0] sval;
      logic [N_SINGLE-1:0] sinv;
      logic [N_SINGLE-1:0] sblk;
      logic [N_SINGLE-1:0] mprev;
      logic [N_SINGLE-1:0] latch;
      logic [N_SINGLE-1:0][CLB_TIME_W-1:0] scnt;
      logic [N_DOUBLE-1:0][1:0] dpat;
      logic [N_DOUBLE-1:0] dinv;
      logic [N_DOUBLE-1:0] dblk;
      logic [N_DOUBLE-1:0][CLB_TIME_W-1:0] dcnt;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic [BL_W-1:0] blink_cnt;
      logic blink;
      logic lclr;
      logic run;
      logic ack;
      logic [31:0] rdata;
   } clb_state_s;

   clb_state_s r;
   clb_state_s nx;

   // source pool: external, then doubles, then single blocks
   function automatic clb_src_s pool(input logic [CLB_SRC_W-1:0] idx);
      clb_src_s s;
      int i;
      s = '0;
      i = int'(idx);
      if (i < N_EXT) begin
         s.a = ext_sig[i].val;
         s.inv = ext_sig[i].inv;
         s.blk = ext_sig[i].blk;
      end else if (i < N_EXT + N_DOUBLE) begin
         s.dbl = 1'b1;
         {s.a, s.b} = r.dpat[i - N_EXT];
         s.inv = r.dinv[i - N_EXT];
         s.blk = r.dblk[i - N_EXT];
      end else if (i < POOL) begin
         s.a = r.sval[i - N_EXT - N_DOUBLE];
         s.inv = r.sinv[i - N_EXT - N_DOUBLE];
         s.blk = r.sblk[i - N_EXT - N_DOUBLE];
      end
      return s;
   endfunction : pool

   function automatic logic qualify(input clb_inp_s c);
      clb_src_s s;
      logic q;
      s = pool(c.src);
      q = 1'b0;
      unique case (c.qual)
         q_on: q = s.dbl ? ({s.a, s.b} == CLB_PAT_ON) : s.a;
         q_off: q = s.dbl ? ({s.a, s.b} == CLB_PAT_OFF) : !s.a;
         q_trn: q = s.dbl & ({s.a, s.b} == CLB_PAT_TRN);
         q_err: q = s.dbl & ({s.a, s.b} == CLB_PAT_ERR);
         q_inv: q = s.inv;
         q_blk: q = s.blk;
         default: q = 1'b0;
      endcase
      return q ^ c.neg;
   endfunction : qualify

   function automatic clb_qsig_s gate(input clb_inp_s [CLB_N_IN-1:0] g, input logic use_or);
      clb_qsig_s o;
      clb_src_s s;
      logic an;
      logic orr;
      logic has_a;
      logic has_o;
      o = '0;
      an = 1'b1;
      orr = 1'b0;
      has_a = 1'b0;
      has_o = 1'b0;
      for (int k = 0; k < CLB_N_IN; k++) begin
         if (int'(g[k].src) < POOL) begin
            s = pool(g[k].src);
            o.inv = o.inv | s.inv;
            o.blk = o.blk | s.blk;
            if (k < CLB_GATE_W) begin
               an = an & qualify(g[k]);
               has_a = 1'b1;
            end else begin
               orr = orr | qualify(g[k]);
               has_o = 1'b1;
            end
         end
      end
      if (!has_a) an = !use_or;
      if (!has_o) orr = !use_or;
      o.val = (has_a | has_o) & (use_or ? (an | orr) : (an & orr));
      return o;
   endfunction : gate

   always_comb begin
      clb_qsig_s g0;
      clb_qsig_s g1;
      clb_qsig_s g2;
      clb_src_s sa;
      clb_src_s sb;
      logic [1:0] pat;
      logic m;
      logic steady;
      logic [CLB_TIME_W-1:0] t;
      logic [CLB_TIME_W-1:0] c;
      logic [1:0] rg;
      logic [5:0] bi;
      logic [5:0] pt;
      logic [255:0] wide;
      g0 = '0;
      g1 = '0;
      g2 = '0;
      sa = '0;
      sb = '0;
      pat = '0;
      m = 1'b0;
      steady = 1'b0;
      t = '0;
      c = '0;
      rg = avs_address[15:14];
      bi = avs_address[13:8];
      pt = avs_address[7:2];
      wide = '0;
      nx = r;

      // evaluation tick
      if (r.tick_cnt == TICK_LAST) begin
         nx.tick_cnt = '0;
         nx.tick = 1'b1;
      end else begin
         nx.tick_cnt = r.tick_cnt + TICK_ONE;
         nx.tick = 1'b0;
      end
      nx.lclr = (r.lclr & !r.tick) | latch_clr;

      if (r.tick) begin
         if (r.blink_cnt == BL_LAST) begin
            nx.blink_cnt = '0;
            nx.blink = !r.blink;
         end else begin
            nx.blink_cnt = r.blink_cnt + BL_ONE;
         end
      end

      if (r.tick & r.run) begin
         // double blocks
         for (int d = 0; d < N_DOUBLE; d++) begin
            sa = pool(r.dcfg[d].src_a);
            sb = pool(r.dcfg[d].src_b);
            pat = {sa.a, sb.a};
            nx.dinv[d] = sa.inv | sb.inv;
            nx.dblk[d] = sa.blk | sb.blk;
            if (pat == CLB_PAT_ON || pat == CLB_PAT_OFF) begin
               nx.dpat[d] = pat;
               nx.dcnt[d] = '0;
            end else if (r.dcnt[d] >= r.dcfg[d].ttime) begin
               if (pat == CLB_PAT_ERR && r.dcfg[d].nstate == four_state_mode) begin
                  nx.dpat[d] = CLB_PAT_ERR;
               end else begin
                  nx.dpat[d] = CLB_PAT_TRN;
               end
            end else begin
               nx.dcnt[d] = r.dcnt[d] + CLB_T_ONE;
            end
         end

         // single blocks, also serving internal inputs, outputs and LEDs
         for (int n = 0; n < N_SINGLE; n++) begin
            g0 = gate(r.inp[n][0 +: CLB_N_IN], r.ctrl[n].merge_or[0]);
            g1 = gate(r.inp[n][CLB_N_IN +: CLB_N_IN], r.ctrl[n].merge_or[1]);
            g2 = gate(r.inp[n][2*CLB_N_IN +: CLB_N_IN], r.ctrl[n].merge_or[2]);
            m = g0.val;
            nx.mprev[n] = m;
            t = r.stime[n];
            c = r.scnt[n];
            if (r.ctrl[n].led) begin
               nx.latch[n] = m | (r.latch[n] & !r.lclr);
               steady = r.ctrl[n].latched ? nx.latch[n] : m;
               nx.sval[n] = g2.val ? r.blink : steady;
               nx.sinv[n] = g0.inv;
               nx.sblk[n] = g0.blk;
               nx.scnt[n] = '0;
            end else begin
               nx.latch[n] = 1'b0;
               nx.sinv[n] = r.ctrl[n].manual_q ? g1.val : g0.inv;
               nx.sblk[n] = r.ctrl[n].manual_q ? g2.val : g0.blk;
               if (t == '0) begin
                  nx.sval[n] = m;
                  nx.scnt[n] = '0;
               end else begin
                  unique case (r.ctrl[n].tkind)
                     pulse_kind: begin
                        if (r.sval[n]) begin
                           if (c >= t) begin
                              nx.sval[n] = 1'b0;
                              nx.scnt[n] = '0;
                           end else begin
                              nx.scnt[n] = c + CLB_T_ONE;
                           end
                        end else if (m & !r.mprev[n]) begin
                           nx.sval[n] = 1'b1;
                           nx.scnt[n] = CLB_T_ONE;
                        end
                     end
                     on_delay_kind: begin
                        if (!m) begin
                           nx.sval[n] = 1'b0;
                           nx.scnt[n] = '0;
                        end else if (c != t) begin
                           nx.scnt[n] = c + CLB_T_ONE;
                           nx.sval[n] = ((c + CLB_T_ONE) == t);
                        end
                     end
                     off_delay_kind: begin
                        if (m) begin
                           nx.sval[n] = 1'b1;
                           nx.scnt[n] = '0;
                        end else if (r.sval[n]) begin
                           if ((c + CLB_T_ONE) >= t) begin
                              nx.sval[n] = 1'b0;
                              nx.scnt[n] = '0;
                           end else begin
                              nx.scnt[n] = c + CLB_T_ONE;
                           end
                        end
                     end
                     default: begin
                        nx.sval[n] = m;
                        nx.scnt[n] = '0;
                     end
                  endcase
               end
            end
         end
      end

      // avalon slave: one wait cycle, then answer
      nx.ack = (avs_read | avs_write) & !r.ack;
      nx.rdata = '0;
      if (avs_read & !r.ack) begin
         unique case (rg)
            CLB_REG_SCFG: begin
               if (int'(bi) < N_SINGLE) begin
                  if (int'(pt) < NIN) nx.rdata = 32'(r.inp[bi][pt]);
                  else if (pt == CLB_PART_CTRL) nx.rdata = 32'(r.ctrl[bi]);
                  else if (pt == CLB_PART_TIME) nx.rdata = 32'(r.stime[bi]);
               end
            end
            CLB_REG_DCFG: begin
               if (int'(bi) < N_DOUBLE && pt == '0) nx.rdata = 32'(r.dcfg[bi]);
            end
            CLB_REG_STAT: begin
               if (bi == '0) begin
                  unique case (pt[5:2])
                     4'h0: wide = 256'(r.sval);
                     4'h1: wide = 256'(r.sinv);
                     4'h2: wide = 256'(r.sblk);
                     4'h3: wide = (pt == CLB_PART_DINV) ? 256'(r.dinv) :
                                  (pt == CLB_PART_DBLK) ? 256'(r.dblk) : 256'(r.dpat);
                     default: wide = '0;
                  endcase
                  if (pt[5:2] == 4'h3 && pt[1]) nx.rdata = wide[31:0];
                  else nx.rdata = wide[32*pt[1:0] +: 32];
               end
            end
            CLB_REG_GLOB: begin
               if (bi == '0 && pt == '0) nx.rdata = {30'h0, r.lclr, r.run};
            end
            default: nx.rdata = '0;
         endcase
      end
      if (avs_write & r.ack) begin
         unique case (rg)
            CLB_REG_SCFG: begin
               if (int'(bi) < N_SINGLE) begin
                  if (int'(pt) < NIN) nx.inp[bi][pt] = avs_writedata[10:0];
                  else if (pt == CLB_PART_CTRL) nx.ctrl[bi] = avs_writedata[7:0];
                  else if (pt == CLB_PART_TIME) nx.stime[bi] = avs_writedata[15:0];
               end
            end
            CLB_REG_DCFG: begin
               if (int'(bi) < N_DOUBLE && pt == '0) nx.dcfg[bi] = avs_writedata[30:0];
            end
            CLB_REG_GLOB: begin
               if (bi == '0 && pt == '0) begin
                  nx.run = avs_writedata[0];
                  nx.lclr = nx.lclr | avs_writedata[1];
               end
            end
            default: nx.run = r.run;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.inp <= {(N_SINGLE * NIN){CLB_INP_RST}};
         r.run <= 1'b1;
      end else begin
         r <= nx;
      end
   end

   for (genvar n = 0; n < N_SINGLE; n++) begin : g_out
      assign single_sig[n] = '{val: r.sval[n], inv: r.sinv[n], blk: r.sblk[n]};
   end
   assign double_pat = r.dpat;
   assign tick = r.tick;
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & !r.ack;
endmodule : clb_top
`default_nettype wire

// ===== src/clb_pkg.sv
package clb_pkg;
   localparam int CLB_N_IN = 12;
   localparam int CLB_GATE_W = 6;
   localparam int CLB_N_SET = 3;
   localparam int CLB_SRC_W = 7;
   localparam int CLB_TIME_W = 16;
   localparam int CLB_CLK_HZ = 20_000_000;
   localparam int CLB_TICK_US = 10_000;
   localparam int CLB_TICK_CYC = CLB_TICK_US * (CLB_CLK_HZ / 1_000_000);
   localparam int CLB_BLINK_MS = 1000;
   localparam int CLB_BLINK_HALF = CLB_BLINK_MS * 1000 / 2 / CLB_TICK_US;
   localparam logic [1:0] CLB_REG_SCFG = 2'h0;
   localparam logic [1:0] CLB_REG_DCFG = 2'h1;
   localparam logic [1:0] CLB_REG_STAT = 2'h2;
   localparam logic [1:0] CLB_REG_GLOB = 2'h3;
   localparam logic [5:0] CLB_PART_CTRL = 6'h24;
   localparam logic [5:0] CLB_PART_TIME = 6'h25;
   localparam logic [5:0] CLB_PART_DINV = 6'h0e;
   localparam logic [5:0] CLB_PART_DBLK = 6'h0f;
   localparam logic [1:0] CLB_PAT_ON = 2'h2;
   localparam logic [1:0] CLB_PAT_OFF = 2'h1;
   localparam logic [1:0] CLB_PAT_TRN = 2'h0;
   localparam logic [1:0] CLB_PAT_ERR = 2'h3;
   localparam logic [CLB_SRC_W-1:0] CLB_SRC_NONE = 7'h7f;
   localparam logic [CLB_TIME_W-1:0] CLB_T_ONE = 16'h0001;

   typedef enum logic [2:0] {q_on, q_off, q_trn, q_err, q_inv, q_blk} clb_qual_e;
   typedef enum logic [1:0] {pulse_kind, on_delay_kind, off_delay_kind} clb_tkind_e;
   typedef enum logic {three_state_mode, four_state_mode} clb_nstate_e;

   typedef struct packed {
      logic val;
      logic inv;
      logic blk;
   } clb_qsig_s;

   typedef struct packed {
      logic a;
      logic b;
      logic dbl;
      logic inv;
      logic blk;
   } clb_src_s;

   typedef struct packed {
      logic neg;
      clb_qual_e qual;
      logic [CLB_SRC_W-1:0] src;
   } clb_inp_s;

   typedef struct packed {
      logic latched;
      logic led;
      clb_tkind_e tkind;
      logic manual_q;
      logic [2:0] merge_or;
   } clb_ctrl_s;

   typedef struct packed {
      logic [CLB_TIME_W-1:0] ttime;
      clb_nstate_e nstate;
      logic [CLB_SRC_W-1:0] src_b;
      logic [CLB_SRC_W-1:0] src_a;
   } clb_dcfg_s;

   localparam clb_inp_s CLB_INP_RST = '{neg: 1'b0, qual: q_on, src: CLB_SRC_NONE};
endpackage : clb_pkg

// ===== verif/clb_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module clb_top_sva import clb_pkg::*; #(
   parameter int N_SINGLE = 64,
   parameter int N_DOUBLE = 16,
   parameter int TICK_CYC = CLB_TICK_CYC
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire clb_qsig_s [N_SINGLE-1:0] single_sig,
   input wire logic [2*N_DOUBLE-1:0] double_pat,
   input wire logic tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // cycles since last tick, 0 until the first one
   logic [31:0] gap;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap <= 32'h0;
      end else if (tick) begin
         gap <= 32'h1;
      end else if (gap != 32'h0) begin
         gap <= gap + 32'h1;
      end
   end
   property p_tick_per;
      gap != 32'h0 |-> tick == (gap == TICK_CYC);
   endproperty
   a_tick_per: assert property (p_tick_per) else $error("tick spacing wrong");
   property p_tick_one;
      tick |=> !tick;
   endproperty
   a_tick_one: assert property (p_tick_one) else $error("tick longer than one cycle");
   property p_sout_hold;
      !$stable(single_sig) |-> $past(tick);
   endproperty
   a_sout_hold: assert property (p_sout_hold) else $error("output moved off tick");
   property p_dpat_hold;
      !$stable(double_pat) |-> $past(tick);
   endproperty
   a_dpat_hold: assert property (p_dpat_hold) else $error("double moved off tick");
   property p_wait_first;
      $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
   property p_wait_idle;
      !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
   property p_rdata_zero;
      !(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0;
   endproperty
   a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer");
   c_tick: cover property (tick);
   c_read: cover property (avs_read && !avs_waitrequest);
   c_write: cover property (avs_write && !avs_waitrequest);
   c_out: cover property ($rose(single_sig[0].val));
endmodule : clb_top_sva
bind clb_top clb_top_sva #(.N_SINGLE(N_SINGLE), .N_DOUBLE(N_DOUBLE), .TICK_CYC(TICK_CYC)) i_sva (
   .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .single_sig(single_sig), .double_pat(double_pat), .tick(tick));
`default_nettype wire

// ===== verif/clb_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module clb_src_model import clb_pkg::*; #(
   parameter int N_EXT = 32
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire clb_qsig_s [N_EXT-1:0] want,
   output clb_qsig_s [N_EXT-1:0] ext_sig
);
   // other relay functions publish new values one clock after asked
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_sig <= '0;
      end else begin
         ext_sig <= want;
      end
   end
endmodule : clb_src_model
`default_nettype wire

// ===== verif/clb_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module clb_top_bench import clb_pkg::*;;
   logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, latch_clr, tick;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   clb_qsig_s [31:0] want, ext_sig;
   clb_qsig_s [63:0] single_sig;
   logic [31:0] double_pat;
   int mismatches, check_count, cyc, m, s, run, idle, rem, tv, cnt;
   logic inb, prev, o;
   logic [1:0] p, st;
   logic [8:0] v;
   logic [63:0] note;
   logic [63:0] exp_q[$];
   localparam logic [15:0] SEQ = 16'h035f;
   localparam logic [23:0] PAT = 24'b10_00_00_01_11_11_11_11_10_00_00_00;
   clb_top #(.TICK_CYC(20)) i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_sig(ext_sig),
      .latch_clr(latch_clr), .single_sig(single_sig), .double_pat(double_pat), .tick(tick));
   clb_src_model i_src (.clk(clk), .sys_rst(sys_rst), .want(want), .ext_sig(ext_sig));
   task automatic close_out();
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic check(input logic [15:0] a, input logic [31:0] mk, input logic [31:0] d);
      exp_q.push_back({mk, d});
      bus(1'b0, a, 32'h0);
   endtask : check
   task automatic cfg(input logic [5:0] b, input logic [5:0] w, input logic [31:0] d);
      bus(1'b1, {2'h0, b, w, 2'h0}, d);
   endtask : cfg
   task automatic inp(input logic [5:0] b, input logic [5:0] i, input logic [2:0] q,
      input logic [6:0] src, input logic n);
      cfg(b, i, {21'h0, n, q, src});
   endtask : inp
   task automatic tk(input int n);
      repeat (n) begin
         do @(negedge clk); while (tick !== 1'b1);
         @(posedge clk);
      end
   endtask : tk
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // read answers are compared against the oldest note
   always @(posedge clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         check_count++;
         note = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hffffffff_ffffffff;
         if ((avs_readdata & note[63:32]) !== note[31:0]) begin
            mismatches++;
            $display("CHECK FAILED %0t read %h expected %h", $time, avs_readdata, note[31:0]);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         mismatches++;
         $display("CHECK FAILED %0t run too long", $time);
         close_out();
      end
   end
   initial begin
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 16'h0;
      avs_writedata = 32'h0;
      latch_clr = 1'b0;
      want = '0;
      mismatches = 0;
      check_count = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      void'($urandom(42921));
      check(16'hc000, 32'h1, 32'h1);
      check(16'h8000, 32'hffffffff, 32'h0);
      check(16'h8050, 32'hffffffff, 32'h0);
      inp(0, 0, q_on, 0, 0);
      inp(0, 1, q_on, 1, 1);
      inp(1, 6, q_off, 2, 0);
      inp(1, 7, q_on, 3, 0);
      for (m = 2; m < 4; m++) begin
         inp(m[5:0], 0, q_on, 0, 0);
         inp(m[5:0], 6, q_on, 2, 0);
      end
      cfg(3, 6'h24, 32'h1);
      inp(4, 0, q_inv, 0, 0);
      inp(5, 0, q_blk, 1, 0);
      inp(6, 0, q_trn, 0, 0);
      inp(7, 0, q_err, 0, 1);
      inp(8, 0, q_on, 0, 0);
      inp(8, 12, q_on, 1, 0);
      cfg(8, 6'h24, 32'h8);
      tk(1);
      for (m = 0; m < 24; m++) begin
         want[3:0] <= 12'($urandom());
         tk(1);
         v = {want[0].val, 2'b10, want[1].blk, want[0].inv, want[0].val | want[2].val,
            want[0].val & want[2].val, !want[2].val | want[3].val, want[0].val & !want[1].val};
         check(16'h8000, 32'h1ff, {23'h0, v});
         check(16'h8010, 32'h101, {23'h0, want[1].val, 7'h0, want[0].inv | want[1].inv});
         check(16'h8020, 32'h1, {31'h0, want[0].blk | want[1].blk});
      end
      inp(9, 0, q_on, 4, 0);
      for (m = 0; m < 4; m++) begin
         tv = (m == 3) ? 0 : 3;
         want[4].val <= 1'b0;
         cfg(9, 6'h24, {26'h0, 2'(m % 3), 4'h0});
         cfg(9, 6'h25, tv);
         tk(4);
         run = 0;
         idle = 0;
         rem = 0;
         prev = 1'b0;
         for (s = 0; s < 16; s++) begin
            want[4].val <= SEQ[s];
            tk(1);
            inb = SEQ[s];
            run = inb ? run + 1 : 0;
            idle = inb ? 0 : idle + 1;
            if (rem == 0 && inb && !prev) rem = tv;
            case (m)
               0: o = rem != 0;
               1: o = run >= tv;
               2: o = inb || idle < tv;
               default: o = inb;
            endcase
            if (rem != 0) rem--;
            prev = inb;
            check(16'h8000, 32'h200, {22'h0, o, 9'h0});
         end
      end
      for (m = 0; m < 2; m++) begin
         bus(1'b1, 16'h4000, {1'b0, 16'h2, m[0], 7'd9, 7'd8});
         cnt = 0;
         for (s = 0; s < 12; s++) begin
            p = PAT[23 - 2 * s -: 2];
            {want[8].val, want[9].val} <= p;
            tk(1);
            cnt = (p == 2'b10 || p == 2'b01) ? 0 : cnt + 1;
            if (cnt == 0) st = p;
            if (cnt > 2) st = (m == 1 || p == 2'b00) ? p : 2'b00;
            check(16'h8030, 32'h3, {30'h0, st});
         end
      end
      inp(10, 0, q_on, 5, 0);
      cfg(10, 6'h24, 32'hc0);
      for (m = 0; m < 2; m++) begin
         want[5].val <= 1'b1;
         tk(1);
         check(16'h8000, 32'h400, 32'h400);
         want[5].val <= 1'b0;
         tk(3);
         check(16'h8000, 32'h400, 32'h400);
         if (m == 0) begin
            @(posedge clk);
            latch_clr <= 1'b1;
            @(posedge clk);
            latch_clr <= 1'b0;
         end else begin
            bus(1'b1, 16'hc000, 32'h3);
         end
         tk(2);
         check(16'h8000, 32'h400, 32'h0);
      end
      // blink led with its steady condition also true
      inp(11, 0, q_on, 5, 0);
      inp(11, 24, q_on, 5, 0);
      cfg(11, 6'h24, 32'h40);
      want[5].val <= 1'b1;
      tk(2);
      @(negedge clk);
      o = single_sig[11].val;
      cnt = 0;
      while (single_sig[11].val === o && cnt < 60) begin
         tk(1);
         @(negedge clk);
         cnt++;
      end
      check(16'h8000, 32'h800, {20'h0, !o, 11'h0});
      tk(49);
      check(16'h8000, 32'h800, {20'h0, !o, 11'h0});
      tk(1);
      check(16'h8000, 32'h800, {20'h0, o, 11'h0});
      close_out();
   end
endmodule : clb_top_bench
`default_nettype wire
